// File: common/acseq_map.vh
`ifndef ACSEQ_MAP_VH
`define ACSEQ_MAP_VH

// register indices on the plain register port
`define ACSEQ_ADDR_CTRL      2'h0
`define ACSEQ_ADDR_MASK      2'h1
`define ACSEQ_ADDR_STATUS    2'h2

// control register fields
`define ACSEQ_CTRL_CODE_LSB  0
`define ACSEQ_CTRL_CODE_MSB  2
`define ACSEQ_CTRL_REF_BIT   3
`define ACSEQ_CTRL_MSEL_BIT  4
`define ACSEQ_CTRL_AUTO_BIT  5
`define ACSEQ_CTRL_CFGL_BIT  6
`define ACSEQ_CTRL_CFGH_BIT  7
`define ACSEQ_CTRL_RESET     8'h00
`define ACSEQ_MASK_RESET     8'h00

// input configurations {high,low}
`define ACSEQ_CFG_SINGLE     2'h0
`define ACSEQ_CFG_DIFF       2'h1
`define ACSEQ_CFG_PSEUDO4    2'h2
`define ACSEQ_CFG_PSEUDO7    2'h3

// selection modes {seq,shadow}
`define ACSEQ_SEL_SINGLE     2'h0
`define ACSEQ_SEL_MASKED     2'h1
`define ACSEQ_SEL_HOLD       2'h2
`define ACSEQ_SEL_CONSEC     2'h3

`endif

// File: src/acseq_channel_sequencer.v
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "acseq_map.vh"

module acseq_channel_sequencer #(
  parameter NCH = 8
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_n,
  // register port
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // conversion start, active low, synchronous
  input  wire       convst_n,
  // multiplexer, reference and conversion start controls
  output reg  [2:0] mux_pos_q,
  output reg  [2:0] mux_neg_q,
  output reg        neg_is_gnd_q,
  output reg        int_ref_en_q,
  output reg        conv_start_q
);

  reg  [7:0] ctrl_q;
  reg  [7:0] mask_q;
  reg  [2:0] chan_q;
  reg  [2:0] chan_d;
  reg        convst_prev_q;
  reg        conv_pulse;
  reg  [2:0] mask_low;
  reg  [2:0] mask_next;
  reg        next_found;
  reg  [1:0] sel_mode;
  reg  [1:0] cfg;
  reg  [2:0] code;
  reg        wr_ctrl;
  reg        keep_run;
  reg  [2:0] pos_d;
  reg  [2:0] neg_d;
  reg        gnd_d;
  reg  [7:0] rdata_d;
  integer    i;
  integer    j;

  always @* begin
    sel_mode = {ctrl_q[`ACSEQ_CTRL_AUTO_BIT], ctrl_q[`ACSEQ_CTRL_MSEL_BIT]};
    cfg      = {ctrl_q[`ACSEQ_CTRL_CFGH_BIT], ctrl_q[`ACSEQ_CTRL_CFGL_BIT]};
    code     = ctrl_q[`ACSEQ_CTRL_CODE_MSB:`ACSEQ_CTRL_CODE_LSB];
    wr_ctrl  = reg_wr && (reg_addr == `ACSEQ_ADDR_CTRL);
    keep_run = ({reg_wdata[`ACSEQ_CTRL_AUTO_BIT],
                 reg_wdata[`ACSEQ_CTRL_MSEL_BIT]} == `ACSEQ_SEL_HOLD);
    conv_pulse = convst_prev_q && !convst_n;
  end

  always @* begin
    mask_low   = 3'h0;
    mask_next  = 3'h0;
    next_found = 1'b0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (mask_q[i]) begin
        mask_low = i[2:0];
      end
      if (mask_q[i] && (i > chan_q)) begin
        mask_next  = i[2:0];
        next_found = 1'b1;
      end
    end
  end

  always @* begin
    chan_d = chan_q;
    if (conv_pulse) begin
      case (sel_mode)
        `ACSEQ_SEL_MASKED: begin
          chan_d = next_found ? mask_next : mask_low;
        end
        `ACSEQ_SEL_CONSEC: begin
          chan_d = (chan_q >= code) ? 3'h0 : chan_q + 3'h1;
        end
        default: begin
          chan_d = chan_q;
        end
      endcase
    end
  end

  // committed control and mask writes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q        <= `ACSEQ_CTRL_RESET;
      mask_q        <= `ACSEQ_MASK_RESET;
      chan_q        <= 3'h0;
      convst_prev_q <= 1'b1;
    end else begin
      convst_prev_q <= convst_n;
      if (reg_wr && (reg_addr == `ACSEQ_ADDR_MASK)) begin
        mask_q <= reg_wdata;
      end
      if (wr_ctrl && !keep_run) begin
        ctrl_q <= reg_wdata;
      end else if (wr_ctrl) begin
        ctrl_q[`ACSEQ_CTRL_REF_BIT]  <= reg_wdata[`ACSEQ_CTRL_REF_BIT];
        ctrl_q[`ACSEQ_CTRL_CFGL_BIT] <= reg_wdata[`ACSEQ_CTRL_CFGL_BIT];
        ctrl_q[`ACSEQ_CTRL_CFGH_BIT] <= reg_wdata[`ACSEQ_CTRL_CFGH_BIT];
      end
      if (wr_ctrl && !keep_run) begin
        case ({reg_wdata[`ACSEQ_CTRL_AUTO_BIT],
               reg_wdata[`ACSEQ_CTRL_MSEL_BIT]})
          `ACSEQ_SEL_SINGLE: chan_q <= reg_wdata[2:0];
          `ACSEQ_SEL_CONSEC: chan_q <= 3'h0;
          default:           chan_q <= mask_low;
        endcase
      end else if (reg_wr && (reg_addr == `ACSEQ_ADDR_MASK) &&
                   (sel_mode == `ACSEQ_SEL_MASKED)) begin
        chan_q <= 3'h0;
        for (j = NCH - 1; j >= 0; j = j - 1) begin
          if (reg_wdata[j]) begin
            chan_q <= j[2:0];
          end
        end
      end else begin
        chan_q <= chan_d;
      end
    end
  end

  // channel to multiplexer mapping per configuration
  always @* begin
    pos_d = chan_q;
    neg_d = 3'h0;
    gnd_d = 1'b0;
    case (cfg)
      `ACSEQ_CFG_SINGLE: begin
        gnd_d = 1'b1;
      end
      `ACSEQ_CFG_DIFF, `ACSEQ_CFG_PSEUDO4: begin
        pos_d = {chan_q[1:0], 1'b0};
        neg_d = {chan_q[1:0], 1'b1};
      end
      `ACSEQ_CFG_PSEUDO7: begin
        pos_d = (chan_q == 3'h7) ? 3'h6 : chan_q;
        neg_d = 3'h7;
      end
      default: begin
        gnd_d = 1'b1;
      end
    endcase
  end

  always @* begin
    case (reg_addr)
      `ACSEQ_ADDR_CTRL:   rdata_d = ctrl_q;
      `ACSEQ_ADDR_MASK:   rdata_d = mask_q;
      `ACSEQ_ADDR_STATUS: rdata_d = {5'h00, chan_q};
      default:            rdata_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= 8'h00;
      mux_pos_q    <= 3'h0;
      mux_neg_q    <= 3'h0;
      neg_is_gnd_q <= 1'b1;
      int_ref_en_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      reg_rdata    <= reg_rd ? rdata_d : 8'h00;
      mux_pos_q    <= pos_d;
      mux_neg_q    <= neg_d;
      neg_is_gnd_q <= gnd_d;
      int_ref_en_q <= ctrl_q[`ACSEQ_CTRL_REF_BIT];
      conv_start_q <= conv_pulse;
    end
  end

endmodule // acseq_channel_sequencer

// File: dv/acseq_props.sv
`timescale 1ns/1ps
module acseq_props (
  // clock and reset
  input wire       ref_clk,
  input wire       rst_n,
  // register port and conversion start
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       convst_n,
  // converter controls
  input wire [2:0] mux_pos_q,
  input wire [2:0] mux_neg_q,
  input wire       neg_is_gnd_q,
  input wire       int_ref_en_q,
  input wire       conv_start_q
);
  wire cw = reg_wr && reg_addr == 2'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  start_pulse_a: assert property (
    $fell(convst_n) |-> ##[1:2] conv_start_q) else $error("no start pulse");
  start_once_a: assert property (
    conv_start_q |=> !conv_start_q) else $error("start pulse too long");
  ref_int_a: assert property (
    cw && reg_wdata[3] |-> ##[1:2] int_ref_en_q) else $error("ref not int");
  ref_ext_a: assert property (
    cw && !reg_wdata[3] |-> ##[1:2] !int_ref_en_q) else $error("ref not ext");
  se_gnd_a: assert property (
    cw && reg_wdata[7:6] == 2'h0 |-> ##2 neg_is_gnd_q) else $error("minus off");
  pair_neg_a: assert property (
    cw && (reg_wdata[7] ^ reg_wdata[6]) |-> ##2 !neg_is_gnd_q && !mux_pos_q[0]
    && mux_neg_q == (mux_pos_q | 3'h1)) else $error("bad pair");
  seven_neg_a: assert property (
    cw && reg_wdata[7:6] == 2'h3 |-> ##2 mux_neg_q == 3'h7 && !neg_is_gnd_q)
    else $error("bad common minus");
  single_pick_a: assert property (
    cw && reg_wdata[7:4] == 4'h0 |-> ##2 mux_pos_q == $past(reg_wdata[2:0], 2))
    else $error("bad single channel");
  consec_zero_a: assert property (
    cw && reg_wdata[7:4] == 4'h3 |-> ##2 mux_pos_q == 3'h0)
    else $error("consecutive not at zero");
endmodule // acseq_props

bind acseq_channel_sequencer acseq_props i_acseq_props (.*);

// File: dv/acseq_host_model.sv
`timescale 1ns/1ps
module acseq_host_model (
  // clock
  input  wire       ref_clk,
  // register port
  output reg  [1:0] reg_addr = 2'h0,
  output reg  [7:0] reg_wdata = 8'h00,
  output reg        reg_wr = 1'b0,
  output reg        reg_rd = 1'b0,
  input  wire [7:0] reg_rdata,
  // conversion start
  output reg        convst_n = 1'b1
);
  task wr(input [1:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(posedge ref_clk);
    #1;
  endtask
  task rd(input [1:0] a, output [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task conv;
    @(posedge ref_clk);
    convst_n <= 1'b0;
    @(posedge ref_clk);
    convst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
endmodule // acseq_host_model

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
  reg        ref_clk = 1'b0;
  reg        rst_n = 1'b0;
  wire [1:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata;
  wire       reg_wr, reg_rd, convst_n, neg_is_gnd_q, int_ref_en_q, conv_start_q;
  wire [2:0] mux_pos_q, mux_neg_q;
  integer    miscompares = 0;
  integer    cmp_count = 0;
  reg  [7:0] d;
  always #5 ref_clk = ~ref_clk;
  acseq_channel_sequencer i_acseq_channel_sequencer (.*);
  acseq_host_model i_acseq_host_model (.*);
  task chk(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task w(input [1:0] a, input [7:0] v);
    i_acseq_host_model.wr(a, v);
  endtask
  task c;
    fork
      i_acseq_host_model.conv;
      begin
        repeat (2) @(posedge ref_clk);
        #1;
        chk(8'(conv_start_q), 8'h01);
      end
    join
  endtask
  task cp(input [7:0] e);
    chk(8'(mux_pos_q), e);
  endtask
  task t_single;
    w(2'h0, 8'h0D);
    cp(8'h05);
    chk(8'({neg_is_gnd_q, int_ref_en_q}), 8'h03);
    c;
    cp(8'h05);
    w(2'h0, 8'h02);
    cp(8'h02);
    chk(8'(int_ref_en_q), 8'h00);
    i_acseq_host_model.rd(2'h2, d);
    chk(d, 8'h02);
    i_acseq_host_model.rd(2'h3, d);
    chk(d, 8'h00);
    $display("single test done");
  endtask
  task t_masked;
    w(2'h0, 8'h10);
    w(2'h1, 8'hA4);
    cp(8'h02);
    c;
    cp(8'h05);
    c;
    cp(8'h07);
    c;
    cp(8'h02);
    w(2'h0, 8'h28);
    cp(8'h02);
    c;
    cp(8'h05);
    w(2'h0, 8'h04);
    c;
    cp(8'h04);
    $display("masked test done");
  endtask
  task t_consec;
    w(2'h0, 8'h32);
    cp(8'h00);
    c;
    cp(8'h01);
    w(2'h0, 8'h20);
    c;
    cp(8'h02);
    c;
    cp(8'h00);
    $display("consecutive test done");
  endtask
  task t_cfg;
    w(2'h0, 8'h83);
    chk({mux_pos_q, mux_neg_q, neg_is_gnd_q}, {3'h6, 3'h7, 1'b0});
    w(2'h0, 8'h41);
    chk({mux_pos_q, mux_neg_q, neg_is_gnd_q}, {3'h2, 3'h3, 1'b0});
    w(2'h0, 8'hC2);
    chk({mux_pos_q, mux_neg_q, neg_is_gnd_q}, {3'h2, 3'h7, 1'b0});
    $display("config test done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_single;
    t_masked;
    t_consec;
    t_cfg;
    summarize;
  end
endmodule // tb
